// [hdl/vci_ahb_slv.sv]
/*
  ahb-lite slave front end: address phase capture, write strobe in
  the data phase with one wait state, registered read data.
  assumes single word transfers; the response is always okay.
*/
`timescale 1ns/10ps
module vci_ahb_slv (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [12:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] rd_data,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic rd_stb,
  output logic wr_stb,
  output logic [12:0] acc_addr
);
  logic accept;
  logic wr_pend_r;
  logic [12:0] wr_addr_r;

  assign accept = hsel && htrans[1] && hready;
  assign rd_stb = accept && !hwrite;
  assign wr_stb = wr_pend_r;
  assign acc_addr = wr_pend_r ? wr_addr_r : haddr;

  // the wait state keeps a following read from seeing stale state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 13'h0000;
      hreadyout <= 1'b1;
    end else begin
      wr_pend_r <= accept && hwrite;
      hreadyout <= !(accept && hwrite);
      if (accept && hwrite) begin
        wr_addr_r <= haddr;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (rd_stb) begin
        hrdata <= rd_data;
      end
    end
  end
endmodule

// [hdl/vci_ctrl.sv]
/*
  virtual cpu interface control: control register, binary points,
  acknowledge, end of interrupt and deactivate over ahb-lite, a small
  set of list register entries, virtual irq/fiq and completion out.
  assumes the hypervisor loads entries over the lr_load port and that
  virtual ids in the entries are unique.
*/
// Chosen here: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
`include "vci_defs.svh"
module vci_ctrl
  import vci_pkg::*;
#(
  parameter int NUM_LR = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic lr_load,
  input wire logic [$clog2(NUM_LR)-1:0] lr_load_index,
  input wire vci_lr_state_t lr_load_state,
  input wire logic [9:0] lr_load_id,
  input wire logic [7:0] lr_load_prio,
  input wire logic lr_load_group,
  input wire logic lr_load_hyp,
  output logic [2*NUM_LR-1:0] lr_state,
  output logic [NUM_LR-1:0] lr_dropped,
  output logic virq,
  output logic vfiq,
  output logic dist_done,
  output logic [9:0] dist_done_id
);
  // ----------------------------------------
  // bus front end
  // ----------------------------------------
  logic rd_stb;
  logic wr_stb;
  logic [12:0] acc_addr;
  logic [31:0] rd_data;

  vci_ahb_slv u_ahb (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr[12:0]),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .rd_data(rd_data),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .rd_stb(rd_stb),
    .wr_stb(wr_stb),
    .acc_addr(acc_addr)
  );

  // ----------------------------------------
  // list register entries
  // ----------------------------------------
  vci_lr_state_t lr_st [NUM_LR];
  logic [9:0] lr_id [NUM_LR];
  logic [7:0] lr_pr [NUM_LR];
  logic [NUM_LR-1:0] lr_grp;
  logic [NUM_LR-1:0] lr_hyp;
  logic [NUM_LR-1:0] ack_v;
  logic [NUM_LR-1:0] drop_v;
  logic [NUM_LR-1:0] deact_v;
  logic [NUM_LR-1:0] act_match;

  for (genvar i = 0; i < NUM_LR; i++) begin : g_lr
    vci_lr_entry u_lr (
      .hclk(hclk),
      .hresetn(hresetn),
      .load(lr_load && lr_load_index == i),
      .load_state(lr_load_state),
      .load_id(lr_load_id),
      .load_prio(lr_load_prio),
      .load_group(lr_load_group),
      .load_hyp(lr_load_hyp),
      .ack(ack_v[i]),
      .drop(drop_v[i]),
      .deact(deact_v[i]),
      .state_r(lr_st[i]),
      .id_r(lr_id[i]),
      .prio_r(lr_pr[i]),
      .group_r(lr_grp[i]),
      .hyp_r(lr_hyp[i]),
      .dropped_r(lr_dropped[i])
    );
    assign lr_state[2*i +: 2] = lr_st[i];
  end

  // ----------------------------------------
  // control and binary point registers
  // ----------------------------------------
  logic [31:0] ctrl_r;
  logic [2:0] bpr_r;
  logic [2:0] abpr_r;
  logic split_mode;
  logic [2:0] bp_g1;

  assign split_mode = ctrl_r[`VCI_SPLIT_EOI_BIT];
  assign bp_g1 = ctrl_r[`VCI_SHARED_BP_BIT] ? bpr_r : abpr_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `VCI_CTRL_RST;
    end else if (wr_stb && acc_addr == `VCI_CTRL_OFS) begin
      ctrl_r <= hwdata & `VCI_CTRL_WMASK;
    end
  end

  // values below the minimum are raised to it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bpr_r <= `VCI_BPR_RST;
      abpr_r <= `VCI_ABPR_RST;
    end else if (wr_stb) begin
      if (acc_addr == `VCI_BPR_OFS) begin
        bpr_r <= (hwdata[2:0] < `VCI_BPR_MIN) ? `VCI_BPR_MIN : hwdata[2:0];
      end
      if (acc_addr == `VCI_ABPR_OFS) begin
        abpr_r <= (hwdata[2:0] < `VCI_ABPR_MIN) ? `VCI_ABPR_MIN : hwdata[2:0];
      end
    end
  end

  // ----------------------------------------
  // running priority and highest pending
  // ----------------------------------------
  function automatic logic [7:0] gmask(input logic [2:0] bp);
    gmask = 8'(8'hff << ({1'b0, bp} + 4'h1));
  endfunction

  logic [7:0] run_pr;
  logic hp_val;
  logic [$clog2(NUM_LR)-1:0] hp_idx;
  logic h1_val;
  logic [$clog2(NUM_LR)-1:0] h1_idx;
  logic sig0;
  logic sig1;
  logic [NUM_LR-1:0] elig;

  always_comb begin
    run_pr = `VCI_IDLE_PRIO;
    for (int i = 0; i < NUM_LR; i++) begin
      if ((lr_st[i] == lr_act || lr_st[i] == lr_actpend) && !lr_dropped[i]
          && lr_pr[i] < run_pr) begin
        run_pr = lr_pr[i];
      end
    end
  end

  // only whole group priorities preempt the running one
  always_comb begin
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < NUM_LR; i++) begin
      m = lr_grp[i] ? gmask(bp_g1) : gmask(bpr_r);
      elig[i] = lr_st[i] == lr_pend && (lr_pr[i] & m) < (run_pr & m)
        && (lr_grp[i] ? ctrl_r[`VCI_EN1_BIT] : ctrl_r[`VCI_EN0_BIT]);
    end
  end

  // lowest index wins a tie in priority
  always_comb begin
    hp_val = 1'b0;
    hp_idx = '0;
    h1_val = 1'b0;
    h1_idx = '0;
    sig0 = 1'b0;
    sig1 = 1'b0;
    for (int i = NUM_LR - 1; i >= 0; i--) begin
      if (elig[i]) begin
        if (!hp_val || lr_pr[i] <= lr_pr[hp_idx]) begin
          hp_val = 1'b1;
          hp_idx = ($clog2(NUM_LR))'(i);
        end
        if (lr_grp[i] && (!h1_val || lr_pr[i] <= lr_pr[h1_idx])) begin
          h1_val = 1'b1;
          h1_idx = ($clog2(NUM_LR))'(i);
        end
        sig0 = sig0 || !lr_grp[i];
        sig1 = sig1 || lr_grp[i];
      end
    end
  end

  // ----------------------------------------
  // acknowledge and read data
  // ----------------------------------------
  logic hp_hidden;
  logic [9:0] iar_id;
  logic [9:0] aiar_id;

  // group 1 stays pending and hidden unless acknowledge control is set
  assign hp_hidden = hp_val && lr_grp[hp_idx] && !ctrl_r[`VCI_ACK_BIT];
  assign iar_id = !hp_val ? `VCI_ID_SPURIOUS :
    hp_hidden ? `VCI_ID_GRP1_HIDDEN : lr_id[hp_idx];
  assign aiar_id = h1_val ? lr_id[h1_idx] : `VCI_ID_SPURIOUS;

  always_comb begin
    ack_v = '0;
    if (rd_stb && acc_addr == `VCI_IAR_OFS && hp_val && !hp_hidden) begin
      ack_v[hp_idx] = 1'b1;
    end
    if (rd_stb && acc_addr == `VCI_AIAR_OFS && h1_val) begin
      ack_v[h1_idx] = 1'b1;
    end
  end

  always_comb begin
    unique case (acc_addr)
      `VCI_CTRL_OFS: rd_data = ctrl_r;
      `VCI_BPR_OFS: rd_data = {29'h0, bpr_r};
      `VCI_ABPR_OFS: rd_data = {29'h0, abpr_r};
      `VCI_IAR_OFS: rd_data = {22'h0, iar_id};
      `VCI_HPPIR_OFS: rd_data = {22'h0, iar_id};
      `VCI_AIAR_OFS: rd_data = {22'h0, aiar_id};
      `VCI_AHPPIR_OFS: rd_data = {22'h0, aiar_id};
      `VCI_RPR_OFS: rd_data = {24'h0, run_pr};
      default: rd_data = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // end of interrupt and deactivate
  // ----------------------------------------
  logic is_eoi;
  logic is_dir;

  assign is_eoi = wr_stb && (acc_addr == `VCI_EOIR_OFS || acc_addr == `VCI_AEOIR_OFS);
  assign is_dir = wr_stb && acc_addr == `VCI_DIR_OFS;

  // a deactivate write in combined mode is dropped on purpose
  always_comb begin
    for (int i = 0; i < NUM_LR; i++) begin
      act_match[i] = (lr_st[i] == lr_act || lr_st[i] == lr_actpend)
        && lr_id[i] == hwdata[9:0];
      drop_v[i] = act_match[i] && is_eoi && split_mode;
      deact_v[i] = act_match[i] && ((is_eoi && !split_mode)
        || (is_dir && split_mode));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dist_done <= 1'b0;
      dist_done_id <= 10'h000;
    end else begin
      dist_done <= |deact_v;
      if (|deact_v) begin
        dist_done_id <= hwdata[9:0];
      end
    end
  end

  // ----------------------------------------
  // virtual request outputs
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      virq <= 1'b0;
      vfiq <= 1'b0;
    end else begin
      vfiq <= sig0 && ctrl_r[`VCI_FIQ_BIT];
      virq <= sig1 || (sig0 && !ctrl_r[`VCI_FIQ_BIT]);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_combined_deact: assert property ((is_eoi && !split_mode && |act_match)
    |-> deact_v == act_match ##1 dist_done)
    else $error("combined eoi did not deactivate");
  a_dir_ignored: assert property ((is_dir && !split_mode) |-> deact_v == '0)
    else $error("deactivate acted in combined mode");
  a_split_eoi: assert property ((is_eoi && split_mode) |->
    (deact_v == '0 && drop_v == act_match))
    else $error("split eoi deactivated or missed drop");
  a_done_report: assert property (|deact_v |=>
    (dist_done && dist_done_id == $past(hwdata[9:0])))
    else $error("completion not reported");
  a_bp_shared: assert property (ctrl_r[`VCI_SHARED_BP_BIT] |-> bp_g1 == bpr_r)
    else $error("shared binary point not used");
  a_fiq_route: assert property (vfiq |-> $past(ctrl_r[`VCI_FIQ_BIT] && sig0))
    else $error("fast request without selection");
  a_hidden_1022: assert property ((rd_stb && acc_addr == `VCI_IAR_OFS && hp_hidden)
    |-> ack_v == '0 ##1 hrdata == 32'h000003fe)
    else $error("hidden group 1 read wrong");
  a_ack_grp1: assert property ((rd_stb && acc_addr == `VCI_IAR_OFS && hp_val
    && lr_grp[hp_idx] && ctrl_r[`VCI_ACK_BIT]) |-> ack_v[hp_idx]
    ##1 hrdata[9:0] == lr_id[$past(hp_idx)] && lr_st[$past(hp_idx)] == lr_act)
    else $error("group 1 acknowledge failed");
  a_grp_off: assert property ((!ctrl_r[`VCI_EN1_BIT] && !ctrl_r[`VCI_EN0_BIT])
    |=> (!virq && !vfiq))
    else $error("signaling while both groups disabled");
  a_spurious: assert property ((rd_stb && acc_addr == `VCI_IAR_OFS && !hp_val)
    |=> hrdata == 32'h000003ff)
    else $error("spurious id missing");
  a_rsvd_zero: assert property ((ctrl_r & ~`VCI_CTRL_WMASK) == 32'h0)
    else $error("reserved control bits set");

  c_iar_ack: cover property (|ack_v);
  c_split_drop: cover property (|drop_v);
  c_dir_deact: cover property (is_dir && |deact_v);
endmodule

// [hdl/vci_defs.svh]
/*
  offsets, field positions, reset values and fixed ids of the
  virtual cpu interface control block.
  assumes a 13-bit word-aligned register window on an ahb-lite slave.
*/
// How it works
// - mode 0: eoi drops and deactivates together
// - deactivation updates entry, reports completion out
// - mode 1: eoi drops, deactivate write deactivates
// - split drop marks entry, stays active
// - shared binary point makes group 1 use the group 0 point
// - group 0 as fast request when selected
// - ack off: group 1 read gives 1022
// - ack on: group 1 read acknowledges interrupt
// - active and pending only for hypervisor entries
// - group 1 enable gates group 1 signaling
// - group 0 enable gates group 0 signaling
// - disabled group reads give spurious id
// - group taken from entry group field
`ifndef VCI_DEFS_SVH
`define VCI_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define VCI_CTRL_OFS 13'h0000
`define VCI_BPR_OFS 13'h0008
`define VCI_IAR_OFS 13'h000c
`define VCI_EOIR_OFS 13'h0010
`define VCI_RPR_OFS 13'h0014
`define VCI_HPPIR_OFS 13'h0018
`define VCI_ABPR_OFS 13'h001c
`define VCI_AIAR_OFS 13'h0020
`define VCI_AEOIR_OFS 13'h0024
`define VCI_AHPPIR_OFS 13'h0028
`define VCI_DIR_OFS 13'h1000

// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define VCI_SPLIT_EOI_BIT 9
`define VCI_SHARED_BP_BIT 4
`define VCI_FIQ_BIT 3
`define VCI_ACK_BIT 2
`define VCI_EN1_BIT 1
`define VCI_EN0_BIT 0
`define VCI_CTRL_WMASK 32'h0000021f
`define VCI_CTRL_RST 32'h00000000
`define VCI_BPR_RST 3'h2
`define VCI_ABPR_RST 3'h3
`define VCI_BPR_MIN 3'h2
`define VCI_ABPR_MIN 3'h3
`define VCI_ID_SPURIOUS 10'h3ff
`define VCI_ID_GRP1_HIDDEN 10'h3fe
`define VCI_IDLE_PRIO 8'hff

`endif

// [hdl/vci_lr_entry.sv]
/*
  one list register entry: state, id, priority, group, origin and
  the priority-dropped mark.
  assumes ack, drop and deact come from the control block.
*/
`timescale 1ns/10ps
module vci_lr_entry
  import vci_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic load,
  input wire vci_lr_state_t load_state,
  input wire logic [9:0] load_id,
  input wire logic [7:0] load_prio,
  input wire logic load_group,
  input wire logic load_hyp,
  input wire logic ack,
  input wire logic drop,
  input wire logic deact,
  output vci_lr_state_t state_r,
  output logic [9:0] id_r,
  output logic [7:0] prio_r,
  output logic group_r,
  output logic hyp_r,
  output logic dropped_r
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= lr_idle;
      id_r <= 10'h000;
      prio_r <= 8'h00;
      group_r <= 1'b0;
      hyp_r <= 1'b0;
      dropped_r <= 1'b0;
    end else if (load) begin
      id_r <= load_id;
      prio_r <= {load_prio[7:3], 3'h0};
      group_r <= load_group;
      hyp_r <= load_hyp;
      dropped_r <= 1'b0;
      // hardware-linked entries cannot be active and pending
      if (load_state == lr_actpend && !load_hyp) begin
        state_r <= lr_act;
      end else begin
        state_r <= load_state;
      end
    end else if (deact) begin
      dropped_r <= 1'b0;
      state_r <= (state_r == lr_actpend) ? lr_pend : lr_idle;
    end else if (ack) begin
      state_r <= lr_act;
    end else if (drop) begin
      dropped_r <= 1'b1;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_no_dual_state: assert property (state_r == lr_actpend |-> hyp_r)
    else $error("active and pending on a hardware entry");
  a_drop_keeps_act: assert property ((drop && !deact && !load && !ack) |=>
    (dropped_r && state_r == $past(state_r)))
    else $error("priority drop changed entry state");
endmodule

// [hdl/vci_pkg.sv]
/*
  shared types of the virtual cpu interface control block.
  assumes nothing of its surroundings.
*/
package vci_pkg;
  typedef enum logic [1:0] {
    lr_idle,
    lr_pend,
    lr_act,
    lr_actpend
  } vci_lr_state_t;
endpackage

// [testbench/vci_far_model.sv]
/*
  far side model: the hypervisor loading list register entries and
  the physical distributor collecting completion reports.
  assumes it is called right after a rising clock edge.
*/
`timescale 1ns/10ps
module vci_far_model
  import vci_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  output logic lr_load,
  output logic [1:0] lr_load_index,
  output vci_lr_state_t lr_load_state,
  output logic [9:0] lr_load_id,
  output logic [7:0] lr_load_prio,
  output logic lr_load_group,
  output logic lr_load_hyp,
  input wire logic dist_done,
  input wire logic [9:0] dist_done_id,
  output logic [31:0] done_cnt,
  output logic [31:0] done_id
);
  // ----------------------------------------
  // entry loading
  // ----------------------------------------
  initial begin
    lr_load = 1'b0;
    lr_load_index = 2'h0;
    lr_load_state = lr_idle;
    lr_load_id = 10'h3ff;
    lr_load_prio = 8'hff;
    lr_load_group = 1'b0;
    lr_load_hyp = 1'b0;
  end

  task automatic load(input logic [1:0] idx, input vci_lr_state_t st, input logic [9:0] id,
                      input logic [7:0] prio, input logic grp, input logic hyp);
    lr_load <= 1'b1;
    lr_load_index <= idx;
    lr_load_state <= st;
    lr_load_id <= id;
    lr_load_prio <= prio;
    lr_load_group <= grp;
    lr_load_hyp <= hyp;
    @(posedge hclk);
    lr_load <= 1'b0;
    // fields are only qualified by the strobe, so scramble id and priority afterwards
    lr_load_id <= ~id;
    lr_load_prio <= ~prio;
    // one idle edge so a following load never lowers and raises the strobe at once
    @(posedge hclk);
  endtask

  // ----------------------------------------
  // completion collector
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_cnt <= 32'h0;
      done_id <= 32'h0;
    end else if (dist_done) begin
      done_cnt <= done_cnt + 32'h1;
      done_id <= {22'h0, dist_done_id};
    end
  end
endmodule

// [testbench/virtual_cpu_iface_control_bench.sv]
/*
  self-checking bench for the virtual cpu interface control block.
  assumes the ahb-lite slave is the only one on the bus.
*/
`timescale 1ns/10ps
`include "vci_defs.svh"
module virtual_cpu_iface_control_bench
  import vci_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic lr_load, lr_load_group, lr_load_hyp, virq, vfiq, dist_done;
  logic [1:0] lr_load_index;
  vci_lr_state_t lr_load_state;
  logic [9:0] lr_load_id, dist_done_id;
  logic [7:0] lr_load_prio, lr_state;
  logic [3:0] lr_dropped;
  logic [31:0] done_cnt, done_id;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;

  always #50 hclk = ~hclk;

  vci_ctrl #(.NUM_LR(4)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lr_load(lr_load),
    .lr_load_index(lr_load_index), .lr_load_state(lr_load_state), .lr_load_id(lr_load_id),
    .lr_load_prio(lr_load_prio), .lr_load_group(lr_load_group), .lr_load_hyp(lr_load_hyp),
    .lr_state(lr_state), .lr_dropped(lr_dropped), .virq(virq), .vfiq(vfiq),
    .dist_done(dist_done), .dist_done_id(dist_done_id));

  vci_far_model fm (.hclk(hclk), .hresetn(hresetn), .lr_load(lr_load),
    .lr_load_index(lr_load_index), .lr_load_state(lr_load_state), .lr_load_id(lr_load_id),
    .lr_load_prio(lr_load_prio), .lr_load_group(lr_load_group), .lr_load_hyp(lr_load_hyp),
    .dist_done(dist_done), .dist_done_id(dist_done_id), .done_cnt(done_cnt),
    .done_id(done_id));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // each phase stands until hready is sampled high at a rising edge
  task automatic bus(input logic w, input logic [12:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {19'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [12:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic sig(input logic ei, input logic ef);
    @(negedge hclk);
    @(negedge hclk);
    chk({30'h0, virq, vfiq}, {30'h0, ei, ef});
    @(posedge hclk);
  endtask

  task automatic st(input int i, input vci_lr_state_t e);
    @(negedge hclk);
    chk({30'h0, lr_state[2*i+:2]}, {30'h0, e});
    @(posedge hclk);
  endtask

  task automatic done(input logic [31:0] n, input logic [31:0] id);
    @(negedge hclk);
    chk(done_cnt, n);
    chk(done_id, id);
    @(posedge hclk);
  endtask

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, cyc, 0);
      complete_run();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(`VCI_CTRL_OFS, 32'h0);
    rdc(`VCI_BPR_OFS, 32'h2);
    rdc(`VCI_ABPR_OFS, 32'h3);
    wr(`VCI_CTRL_OFS, 32'hffffffff);
    rdc(`VCI_CTRL_OFS, 32'h0000021f);
    wr(`VCI_BPR_OFS, 32'h1);
    rdc(`VCI_BPR_OFS, 32'h2);
    rdc(13'h002c, 32'h0);
    // group 0 and group 1, combined mode
    wr(`VCI_CTRL_OFS, 32'h0);
    fm.load(2'h0, lr_pend, 10'h005, 8'h40, 1'b0, 1'b0);
    rdc(`VCI_IAR_OFS, 32'h3ff);
    sig(1'b0, 1'b0);
    wr(`VCI_CTRL_OFS, 32'h1);
    sig(1'b1, 1'b0);
    wr(`VCI_CTRL_OFS, 32'h9);
    sig(1'b0, 1'b1);
    rdc(`VCI_IAR_OFS, 32'h005);
    st(0, lr_act);
    wr(`VCI_EOIR_OFS, 32'h005);
    done(32'h1, 32'h005);
    st(0, lr_idle);
    fm.load(2'h2, lr_act, 10'h009, 8'h40, 1'b1, 1'b0);
    wr(`VCI_DIR_OFS, 32'h009);
    done(32'h1, 32'h005);
    st(2, lr_act);
    wr(`VCI_AEOIR_OFS, 32'h009);
    done(32'h2, 32'h009);
    st(2, lr_idle);
    // split mode: drop first, deactivate later
    wr(`VCI_CTRL_OFS, 32'h209);
    fm.load(2'h1, lr_pend, 10'h007, 8'h40, 1'b0, 1'b0);
    rdc(`VCI_IAR_OFS, 32'h007);
    wr(`VCI_EOIR_OFS, 32'h007);
    done(32'h2, 32'h009);
    chk({31'h0, lr_dropped[1]}, 32'h1);
    st(1, lr_act);
    wr(`VCI_DIR_OFS, 32'h007);
    done(32'h3, 32'h007);
    st(1, lr_idle);
    // group 1 acknowledge control
    wr(`VCI_CTRL_OFS, 32'h3);
    fm.load(2'h3, lr_pend, 10'h021, 8'h40, 1'b1, 1'b0);
    rdc(`VCI_IAR_OFS, 32'h3fe);
    st(3, lr_pend);
    sig(1'b1, 1'b0);
    wr(`VCI_CTRL_OFS, 32'h1);
    sig(1'b0, 1'b0);
    rdc(`VCI_IAR_OFS, 32'h3ff);
    wr(`VCI_CTRL_OFS, 32'h7);
    rdc(`VCI_IAR_OFS, 32'h021);
    st(3, lr_act);
    wr(`VCI_CTRL_OFS, 32'h3);
    // active and pending only for hypervisor entries
    fm.load(2'h0, lr_actpend, 10'h030, 8'h80, 1'b0, 1'b0);
    st(0, lr_act);
    fm.load(2'h0, lr_actpend, 10'h030, 8'h80, 1'b0, 1'b1);
    st(0, lr_actpend);
    for (int i = 0; i < 4; i++) fm.load(2'(i), lr_idle, 10'h0, 8'h0, 1'b0, 1'b0);
    // coarse aliased point blocks group 1 preemption, shared fine point allows it
    wr(`VCI_ABPR_OFS, 32'h7);
    rdc(`VCI_ABPR_OFS, 32'h7);
    fm.load(2'h0, lr_act, 10'h011, 8'h40, 1'b0, 1'b0);
    fm.load(2'h1, lr_pend, 10'h012, 8'h30, 1'b1, 1'b0);
    sig(1'b0, 1'b0);
    wr(`VCI_CTRL_OFS, 32'h13);
    sig(1'b1, 1'b0);
    complete_run();
  end
endmodule
